// ---- src/led_drv_map.svh ----
`ifndef LED_DRV_MAP_SVH
`define LED_DRV_MAP_SVH

`define LED_PINS 35
`define LED_COMS 5
`define LED_LATCHES 175

`define LED_OFS_CTRL 12'h000
`define LED_OFS_CMD 12'h004
`define LED_OFS_LOAD 12'h008
`define LED_OFS_IDX 12'h00C
`define LED_OFS_LCFG 12'h010
`define LED_OFS_DC0 12'h014
`define LED_OFS_DC1 12'h018
`define LED_OFS_STAT 12'h01C

`define LED_CTRL_HICOM 0
`define LED_CTRL_BIAS 1
`define LED_CTRL_DUTY_LSB 4
`define LED_CTRL_SPEED_LSB 8
`define LED_CMD_ON 0
`define LED_CMD_OFF 1
`define LED_LD_SEL_LSB 0
`define LED_LD_TABLE 5
`define LED_LD_WREG_LSB 8
`define LED_LD_ACC_LSB 12
`define LED_LD_TWORD_LSB 16
`define LED_ST_DISP 0
`define LED_ST_STOP 1
`define LED_ST_SLOT_LSB 4
`define LED_ST_CAP_LSB 8
`define LED_ST_COM_LSB 16

`define LED_DUTY_RST 3'h4
`define LED_SPEED_RST 2'h1
`define LED_DISP_RST 1'h1
`define LED_HICOM_RST 1'h0

`define LED_COM_DC_PP 4'h0
`define LED_COM_DC_OD 4'h9
`define LED_COM_MAX 4'h5

`define LED_CLK_HZ 100000000
`define LED_PREDIV_HZ 32768
`define LED_SLOT_D1 11'h100
`define LED_SLOT_D2 11'h100
`define LED_SLOT_D3 11'h080
`define LED_SLOT_D4 11'h080
`define LED_SLOT_D5 11'h040

`endif

// ---- src/led_drv_pkg.sv ----
`include "led_drv_map.svh"
package led_drv_pkg;
	typedef enum logic [2:0] {
		DUTY_STATIC = 3'b000,
		DUTY_2 = 3'b001,
		DUTY_3 = 3'b010,
		DUTY_4 = 3'b011,
		DUTY_5 = 3'b100
	} duty_e;
	typedef enum logic [1:0] {
		SPD_SLOW = 2'b00,
		SPD_TYP = 2'b01,
		SPD_FAST = 2'b10
	} speed_e;
	typedef struct packed {
		logic [3:0] common_line;
		logic [4:0] strobe;
		logic [2:0] bitSel;
	} latch_cfg_s;
	typedef struct packed {
		logic [`LED_LATCHES-1:0] pix;
		latch_cfg_s [`LED_LATCHES-1:0] cfg;
		logic [`LED_PINS-1:0] dcData;
		logic [7:0] idx;
		duty_e duty;
		speed_e speed;
		logic highCom;
		logic halfBias;
		logic dispOn;
		logic rdOk;
		logic [31:0] rdData;
		logic slvErr;
		logic [`LED_PINS-1:0] segment_line;
		logic [`LED_PINS-1:0] segOe;
		logic [`LED_COMS-1:0] common_line;
	} drv_state_s;
	typedef struct packed {
		logic [26:0] phase;
		logic [10:0] tickCnt;
		logic [2:0] slot;
		logic slotTick;
	} scan_state_s;
endpackage

// ---- src/led_segment_matrix_driver.sv ----
`timescale 1ns/1ps
`include "led_drv_map.svh"
module led_segment_matrix_driver #(
	parameter int CLK_HZ = `LED_CLK_HZ,
	parameter int PREDIV_HZ = `LED_PREDIV_HZ
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic stopMode,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [`LED_PINS-1:0] segmentLine,
	output logic [`LED_PINS-1:0] segmentLineOe,
	output logic [`LED_COMS-1:0] commonLine
);
	led_drv_pkg::drv_state_s s;
	led_drv_pkg::drv_state_s n;
	logic apbDone;
	logic badAccess;
	logic loadFire;
	logic run;
	logic [7:0] patternBus;
	logic [31:0] latchStrobe;
	logic [`LED_PINS-1:0] lit;
	logic [`LED_PINS-1:0] pinLed;
	logic act;

	scan_if sif();

	function automatic logic comLegal(logic [3:0] c);
		comLegal = (c <= `LED_COM_MAX) || (c == `LED_COM_DC_OD);
	endfunction

	function automatic logic mapped(logic [11:0] a);
		case (a)
			`LED_OFS_CTRL, `LED_OFS_CMD, `LED_OFS_LOAD, `LED_OFS_IDX,
			`LED_OFS_LCFG, `LED_OFS_DC0, `LED_OFS_DC1, `LED_OFS_STAT: mapped = 1'h1;
			default: mapped = 1'h0;
		endcase
	endfunction

	// Pixels that one scan frame can address
	function automatic logic [7:0] capacity(led_drv_pkg::duty_e d);
		capacity = 8'(`LED_PINS * (int'(d) + 1));
	endfunction

	function automatic led_drv_pkg::drv_state_s rstState();
		led_drv_pkg::drv_state_s r;
		r = '0;
		r.duty = led_drv_pkg::duty_e'(`LED_DUTY_RST);
		r.speed = led_drv_pkg::speed_e'(`LED_SPEED_RST);
		r.dispOn = `LED_DISP_RST;
		r.highCom = `LED_HICOM_RST;
		r.segment_line = '1;
		r.segOe = '1;
		r.common_line = {`LED_COMS{!`LED_HICOM_RST}};
		// Latch i sits on pin i/5 and common (i%5)+1 until reconfigured
		for (int i = 0; i < `LED_LATCHES; i++) begin
			r.cfg[i].common_line = 4'(i % `LED_COMS + 1);
		end
		rstState = r;
	endfunction

	localparam led_drv_pkg::drv_state_s RST_STATE = rstState();

	function automatic logic [31:0] readWord(logic [11:0] a);
		readWord = 32'h00000000;
		case (a)
			`LED_OFS_CTRL: begin
				readWord[`LED_CTRL_HICOM] = s.highCom;
				readWord[`LED_CTRL_BIAS] = s.halfBias;
				readWord[`LED_CTRL_DUTY_LSB+:3] = s.duty;
				readWord[`LED_CTRL_SPEED_LSB+:2] = s.speed;
			end
			`LED_OFS_IDX: readWord[7:0] = s.idx;
			`LED_OFS_LCFG: begin
				if (s.idx < 8'(`LED_LATCHES)) begin
					readWord[11:0] = s.cfg[s.idx];
				end
			end
			`LED_OFS_DC0: readWord = s.dcData[31:0];
			`LED_OFS_DC1: readWord[2:0] = s.dcData[`LED_PINS-1:32];
			`LED_OFS_STAT: begin
				readWord[`LED_ST_DISP] = s.dispOn;
				readWord[`LED_ST_STOP] = stopMode;
				readWord[`LED_ST_SLOT_LSB+:3] = sif.slot;
				readWord[`LED_ST_CAP_LSB+:8] = capacity(s.duty);
				readWord[`LED_ST_COM_LSB+:`LED_COMS] = s.common_line;
			end
			default: readWord = 32'h00000000;
		endcase
	endfunction

	// Zero wait after the setup edge; a frozen setup edge adds one
	assign apbDone = ce && psel && penable && s.rdOk;
	assign pready = apbDone;
	assign pslverr = apbDone && s.slvErr;
	assign prdata = s.rdData;
	assign badAccess = !mapped(paddr) || (pwrite && paddr == `LED_OFS_LCFG
		&& (s.idx >= 8'(`LED_LATCHES) || !comLegal(pwdata[11:8])));
	assign loadFire = apbDone && pwrite && !s.slvErr && paddr == `LED_OFS_LOAD;
	assign run = s.dispOn && !stopMode;

	assign sif.duty = s.duty;
	assign sif.speed = s.speed;
	assign sif.run = run;

	pattern_source u_pattern (
		.tableLoad(pwdata[`LED_LD_TABLE]),
		.workReg(pwdata[`LED_LD_WREG_LSB+:4]),
		.accumulator(pwdata[`LED_LD_ACC_LSB+:4]),
		.tableWord(pwdata[`LED_LD_TWORD_LSB+:8]),
		.latchSelect(pwdata[`LED_LD_SEL_LSB+:5]),
		.patternBus(patternBus),
		.latchStrobe(latchStrobe)
	);

	scan_timer #(
		.CLK_HZ(CLK_HZ),
		.PREDIV_HZ(PREDIV_HZ)
	) u_scan (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.sif(sif)
	);

	always_comb begin
		n = s;
		lit = '0;
		pinLed = '0;
		act = 1'h0;
		if (psel && !s.rdOk) begin
			n.rdOk = 1'h1;
			n.rdData = readWord(paddr);
			n.slvErr = badAccess;
		end
		if (apbDone) begin
			n.rdOk = 1'h0;
			if (pwrite && !s.slvErr) begin
				case (paddr)
					`LED_OFS_CTRL: begin
						n.highCom = pwdata[`LED_CTRL_HICOM];
						n.halfBias = pwdata[`LED_CTRL_BIAS];
						// Reserved duty and speed codes leave the old setting
						if (pwdata[`LED_CTRL_DUTY_LSB+:3] <= 3'(led_drv_pkg::DUTY_5)) begin
							n.duty = led_drv_pkg::duty_e'(pwdata[`LED_CTRL_DUTY_LSB+:3]);
						end
						if (pwdata[`LED_CTRL_SPEED_LSB+:2] != 2'h3) begin
							n.speed = led_drv_pkg::speed_e'(pwdata[`LED_CTRL_SPEED_LSB+:2]);
						end
					end
					`LED_OFS_CMD: begin
						// Off wins if both bits are set; latches untouched
						if (pwdata[`LED_CMD_OFF]) begin
							n.dispOn = 1'h0;
						end else if (pwdata[`LED_CMD_ON]) begin
							n.dispOn = 1'h1;
						end
					end
					`LED_OFS_IDX: n.idx = pwdata[7:0];
					`LED_OFS_LCFG: n.cfg[s.idx] = led_drv_pkg::latch_cfg_s'(pwdata[11:0]);
					`LED_OFS_DC0: n.dcData[31:0] = pwdata;
					`LED_OFS_DC1: n.dcData[`LED_PINS-1:32] = pwdata[2:0];
					default: n.idx = s.idx;
				endcase
			end
		end
		// Loads land even while off or stopped, shown once running
		if (loadFire) begin
			for (int i = 0; i < `LED_LATCHES; i++) begin
				if (latchStrobe[s.cfg[i].strobe]) begin
					n.pix[i] = patternBus[s.cfg[i].bitSel];
				end
			end
		end
		// Every latch of a pin is scanned; a pin may light in several slots
		// Segment and common both register from the same slot value,
		// so they change on the same edge and no ghosting shows
		for (int p = 0; p < `LED_PINS; p++) begin
			for (int k = 0; k < `LED_COMS; k++) begin
				if (s.pix[p*`LED_COMS+k]
					&& s.cfg[p*`LED_COMS+k].common_line == 4'(sif.slot) + 4'h1) begin
					lit[p] = 1'h1;
				end
			end
			// First latch of a pin decides whether the pin is DC
			if (s.cfg[p*`LED_COMS].common_line == `LED_COM_DC_PP) begin
				n.segment_line[p] = s.dcData[p];
				n.segOe[p] = 1'h1;
			end else if (s.cfg[p*`LED_COMS].common_line == `LED_COM_DC_OD) begin
				n.segment_line[p] = 1'h1;
				n.segOe[p] = s.dcData[p];
			end else begin
				pinLed[p] = 1'h1;
				n.segment_line[p] = !(run && lit[p]);
				n.segOe[p] = 1'h1;
			end
		end
		// Commons beyond the duty count stay at their idle level
		for (int c = 0; c < `LED_COMS; c++) begin
			act = run && sif.slot == 3'(c) && 3'(c) <= 3'(s.duty);
			n.common_line[c] = s.highCom ? act : !act;
		end
	end

	// Reset wins over a low clock enable
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s <= RST_STATE;
		end else if (ce) begin
			s <= n;
		end
	end

	assign segmentLine = s.segment_line;
	assign segmentLineOe = s.segOe;
	assign commonLine = s.common_line;

	// Display-side checks; bus timing is exercised by the bench
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_off_commons_idle: assert property (
		(ce && !run) |=> commonLine == {`LED_COMS{!$past(s.highCom)}})
		else $error("common active while display idle");
	a_off_segs_unlit: assert property (
		(ce && !run) |=> (segmentLine | ~$past(pinLed)) == '1)
		else $error("segment lit while display idle");
	a_reset_pix_clear: assert property (
		$fell(sys_rst) |-> s.pix == '0)
		else $error("pixels not cleared by reset");
	// Outputs leave reset dark, so no pixel draws current at power-up
	a_reset_dark: assert property (
		$fell(sys_rst) |-> (segmentLine == '1 && commonLine == {`LED_COMS{!`LED_HICOM_RST}}))
		else $error("outputs not dark after reset");
	// Stop must darken the panel although the display flag stays set
	a_stop_dark: assert property (
		(ce && stopMode) |=> commonLine == {`LED_COMS{!$past(s.highCom)}})
		else $error("common active in stop");
	// Open-drain pin only ever drives high, enable follows data
	a_od_enable: assert property (
		(ce && s.cfg[0].common_line == `LED_COM_DC_OD) |=> segmentLineOe[0] == $past(s.dcData[0]))
		else $error("open-drain pin enable wrong");
	a_on_cmd: assert property (
		(apbDone && pwrite && !s.slvErr && paddr == `LED_OFS_CMD
		&& pwdata[`LED_CMD_ON] && !pwdata[`LED_CMD_OFF]) |=> s.dispOn)
		else $error("display-on not taken");
	a_cmd_keeps_pix: assert property (
		(apbDone && paddr == `LED_OFS_CMD) |=> s.pix == $past(s.pix))
		else $error("on or off changed pixels");
	a_load_latch0: assert property (
		(loadFire && latchStrobe[s.cfg[0].strobe])
		|=> s.pix[0] == $past(patternBus[s.cfg[0].bitSel]))
		else $error("latch 0 missed its strobe");
	a_bad_com_refused: assert property (
		(apbDone && pwrite && paddr == `LED_OFS_LCFG && !comLegal(pwdata[11:8]))
		|-> pslverr ##1 s.cfg == $past(s.cfg))
		else $error("illegal common code accepted");
	a_one_common: assert property (
		$past(ce) |-> $onehot0(commonLine ^ {`LED_COMS{!$past(s.highCom)}}))
		else $error("more than one common active");
	a_dc_hold: assert property (
		(ce && s.cfg[0].common_line == `LED_COM_DC_PP) |=> segmentLine[0] == $past(s.dcData[0]))
		else $error("DC pin lost its data");

	c_display_off: cover property (apbDone && paddr == `LED_OFS_CMD && pwdata[`LED_CMD_OFF]);
	c_load_fire: cover property (loadFire && pwdata[`LED_LD_TABLE]);
	c_dc_pin: cover property (s.cfg[0].common_line == `LED_COM_DC_OD && s.dcData[0]);
	c_lit_slot: cover property (run && (segmentLine & pinLed) != pinLed);
endmodule

// ---- src/pattern_source.sv ----
`timescale 1ns/1ps
module pattern_source (
	input wire logic tableLoad,
	input wire logic [3:0] workReg,
	input wire logic [3:0] accumulator,
	input wire logic [7:0] tableWord,
	input wire logic [4:0] latchSelect,
	output logic [7:0] patternBus,
	output logic [31:0] latchStrobe
);
	assign patternBus = tableLoad ? tableWord : {accumulator, workReg};
	assign latchStrobe = 32'h00000001 << latchSelect;
endmodule

// ---- src/scan_if.sv ----
`timescale 1ns/1ps
interface scan_if;
	led_drv_pkg::duty_e duty;
	led_drv_pkg::speed_e speed;
	logic run;
	logic [2:0] slot;
	logic slotTick;
	modport timer(input duty, input speed, input run, output slot, output slotTick);
	modport user(output duty, output speed, output run, input slot, input slotTick);
endinterface

// ---- src/scan_timer.sv ----
`timescale 1ns/1ps
`include "led_drv_map.svh"
module scan_timer #(
	parameter int CLK_HZ = `LED_CLK_HZ,
	parameter int PREDIV_HZ = `LED_PREDIV_HZ
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	scan_if.timer sif
);
	led_drv_pkg::scan_state_s s;
	led_drv_pkg::scan_state_s n;
	logic [27:0] sum;
	logic preTick;

	// Slot length in predivider ticks; frame = slot length times duty
	function automatic logic [10:0] slotLen(led_drv_pkg::duty_e d, led_drv_pkg::speed_e v);
		logic [10:0] b;
		case (d)
			led_drv_pkg::DUTY_STATIC: b = `LED_SLOT_D1;
			led_drv_pkg::DUTY_2: b = `LED_SLOT_D2;
			led_drv_pkg::DUTY_3: b = `LED_SLOT_D3;
			led_drv_pkg::DUTY_4: b = `LED_SLOT_D4;
			default: b = `LED_SLOT_D5;
		endcase
		case (v)
			led_drv_pkg::SPD_SLOW: slotLen = b << 1;
			led_drv_pkg::SPD_FAST: slotLen = b >> 1;
			default: slotLen = b;
		endcase
	endfunction

	always_comb begin
		n = s;
		n.slotTick = 1'h0;
		// Fractional accumulator gives an exact average predivider rate
		sum = 28'(s.phase) + 28'(PREDIV_HZ);
		preTick = sum >= 28'(CLK_HZ);
		n.phase = preTick ? 27'(sum - 28'(CLK_HZ)) : 27'(sum);
		if (!sif.run) begin
			n.tickCnt = 11'h000;
			n.slot = 3'h0;
		end else if (preTick) begin
			if (s.tickCnt + 11'h001 >= slotLen(sif.duty, sif.speed)) begin
				n.tickCnt = 11'h000;
				n.slotTick = 1'h1;
				n.slot = (s.slot >= 3'(sif.duty)) ? 3'h0 : s.slot + 3'h1;
			end else begin
				n.tickCnt = s.tickCnt + 11'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign sif.slot = s.slot;
	assign sif.slotTick = s.slotTick;

	a_phase_bound: assert property (@(posedge clk) disable iff (sys_rst)
		s.phase < 27'(CLK_HZ)) else $error("predivider phase out of range");
	a_slot_step: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && sif.run && s.slotTick && s.slot == 3'h0 && $past(s.slot) != 3'h0)
		|-> $past(s.slot) >= 3'($past(sif.duty))) else $error("slot wrapped early");
	c_slot_wrap: cover property (@(posedge clk) disable iff (sys_rst)
		s.slotTick && s.slot == 3'h0);
endmodule

// ---- verification/led_panel_model.sv ----
`timescale 1ns/1ps
module led_panel_model (
	input wire logic highCom,
	input wire logic [34:0] segment_line,
	input wire logic [34:0] segOe,
	input wire logic [4:0] common_line,
	output logic [2:0] comIdx,
	output logic [34:0] lit
);
	logic [4:0] on;
	always_comb begin
		on = highCom ? common_line : ~common_line;
		comIdx = 3'h0;
		for (int i = 0; i < 5; i++) begin
			if (on[i]) begin
				// Two rows at once would short the panel, so flag it as 7
				comIdx = (comIdx == 3'h0) ? 3'(i + 1) : 3'h7;
			end
		end
		// A pin lights only while driven low under exactly one live row
		lit = (comIdx inside {[3'h1:3'h5]}) ? (segOe & ~segment_line) : 35'h0;
	end
endmodule

// ---- verification/test_led_segment_matrix_driver.sv ----
`timescale 1ns/1ps
module test_led_segment_matrix_driver;
	typedef struct {
		logic [11:0] a;
		logic w;
		logic [31:0] d;
		logic [31:0] m;
		logic e;
	} row_s;
	logic clk = 1'b0;
	logic ce = 1'b1;
	logic sys_rst = 1'b1;
	logic stopMode = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [34:0] segment_line;
	logic [34:0] segOe;
	logic [4:0] common_line;
	logic highCom = 1'b0;
	logic [2:0] comIdx;
	logic [34:0] lit;
	logic [31:0] rd;
	logic er;
	int n_fail = 0;
	int num_checks = 0;
	int cnt;
	int base [5] = '{256, 256, 128, 128, 64};
	row_s rows [12] = '{
		'{12'h000, 1'b0, 32'h0000_0140, 32'hFFFF_FFFF, 1'b0},
		'{12'h01C, 1'b0, 32'h001E_AF01, 32'h001F_FF03, 1'b0},
		'{12'h020, 1'b0, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1},
		'{12'h7FC, 1'b1, 32'h0000_0001, 32'h0000_0000, 1'b1},
		'{12'h004, 1'b0, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0},
		'{12'h000, 1'b1, 32'h0000_0170, 32'h0000_0000, 1'b0},
		'{12'h000, 1'b0, 32'h0000_0140, 32'hFFFF_FFFF, 1'b0},
		'{12'h00C, 1'b1, 32'h0000_00AF, 32'h0000_0000, 1'b0},
		'{12'h010, 1'b1, 32'h0000_0100, 32'h0000_0000, 1'b1},
		'{12'h00C, 1'b1, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{12'h010, 1'b1, 32'h0000_0600, 32'h0000_0000, 1'b1},
		'{12'h010, 1'b1, 32'h0000_0A00, 32'h0000_0000, 1'b1}
	};

	always #5 clk = ~clk;

	led_segment_matrix_driver #(.CLK_HZ(65536), .PREDIV_HZ(32768)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .ce(ce), .stopMode(stopMode),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.segmentLine(segment_line), .segmentLineOe(segOe), .commonLine(common_line)
	);

	led_panel_model panel_u (
		.highCom(highCom), .segment_line(segment_line), .segOe(segOe), .common_line(common_line),
		.comIdx(comIdx), .lit(lit)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Inputs only move at rising edges, so the value seen here stands at the next one
		do begin
			@(negedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		@(posedge clk);
		if (k >= 50) n_fail++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d, rd, er);
	endtask

	// Sampled on the falling edge so flop updates have landed
	task automatic wait_com(input logic [2:0] c);
		int k;
		k = 0;
		while (comIdx !== c && k < 5000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 5000) n_fail++;
		repeat (3) @(negedge clk);
	endtask

	task automatic close_out();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#1_000_000;
		n_fail++;
		close_out();
	end

	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk({segment_line[31:0]}, 32'hFFFF_FFFF);
		chk({27'h0, common_line}, 32'h0000_001F);
		$display("test reset done");
		foreach (rows[i]) begin
			xfer(rows[i].a, rows[i].w, rows[i].d, rd, er);
			if (!rows[i].w) chk(rd & rows[i].m, rows[i].d);
			chk({31'h0, er}, {31'h0, rows[i].e});
		end
		$display("test rows done");
		for (int d = 0; d < 5; d++) begin
			wr(12'h000, 32'h0000_0100 | 32'(d << 4));
			xfer(12'h01C, 1'b0, 32'h0, rd, er);
			chk({24'h0, rd[15:8]}, 32'(35 * (d + 1)));
		end
		$display("test capacity done");
		for (int d = 1; d < 5; d++) begin
			for (int s = 0; s < 3; s++) begin
				wr(12'h000, 32'((s << 8) | (d << 4)));
				wait_com(3'h2);
				wait_com(3'h1);
				cnt = 3;
				while (comIdx !== 3'h2 && cnt < 5000) begin
					@(negedge clk);
					cnt++;
				end
				chk(32'(cnt), 32'((base[d] * 4) >> s));
			end
		end
		$display("test rates done");
		wr(12'h000, 32'h0000_0141);
		highCom = 1'b1;
		wr(12'h00C, 32'h0000_0007);
		wr(12'h010, 32'h0000_03FD);
		wr(12'h00C, 32'h0000_000C);
		wr(12'h010, 32'h0000_03F7);
		wr(12'h00C, 32'h0000_0011);
		wr(12'h010, 32'h0000_03EA);
		wr(12'h008, 32'h0000_201F);
		wr(12'h008, 32'h0080_003E);
		wr(12'h008, 32'h0000_041D);
		wait_com(3'h3);
		chk({27'h0, lit[4:0]}, 32'h0000_000E);
		chk({27'h0, common_line}, 32'h0000_0004);
		wait_com(3'h1);
		chk({27'h0, lit[4:0]}, 32'h0000_0000);
		@(posedge clk);
		ce <= 1'b0;
		@(negedge clk);
		rd = {27'h0, common_line};
		repeat (200) @(negedge clk);
		chk({27'h0, common_line}, rd);
		@(posedge clk);
		ce <= 1'b1;
		$display("test scan done");
		wr(12'h004, 32'h0000_0002);
		repeat (3) @(negedge clk);
		chk({22'h0, common_line, segment_line[4:0]}, 32'h0000_001F);
		wr(12'h00C, 32'h0000_0016);
		wr(12'h010, 32'h0000_03E0);
		wr(12'h008, 32'h0000_011C);
		chk({27'h0, segment_line[4:0]}, 32'h0000_001F);
		wr(12'h004, 32'h0000_0001);
		wait_com(3'h3);
		chk({27'h0, lit[4:0]}, 32'h0000_001E);
		$display("test display off done");
		wr(12'h00C, 32'h0000_001E);
		wr(12'h010, 32'h0000_0000);
		wr(12'h00C, 32'h0000_0023);
		wr(12'h010, 32'h0000_0900);
		wr(12'h014, 32'h0000_00C0);
		@(posedge clk);
		stopMode <= 1'b1;
		repeat (3) @(negedge clk);
		chk({28'h0, segment_line[7:6], segOe[7:6]}, 32'h0000_000F);
		chk({22'h0, common_line, segment_line[4:0]}, 32'h0000_001F);
		wr(12'h014, 32'h0000_0040);
		repeat (2) @(negedge clk);
		chk({28'h0, segment_line[7:6], segOe[7:6]}, 32'h0000_000D);
		$display("test dc pins done");
		@(posedge clk);
		sys_rst <= 1'b1;
		stopMode <= 1'b0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		highCom = 1'b0;
		@(negedge clk);
		chk({27'h0, common_line}, 32'h0000_001F);
		wait_com(3'h3);
		chk(lit[31:0], 32'h0000_0000);
		$display("test mid reset done");
		close_out();
	end
endmodule
